// >>> rtl/thb_defines.svh
// constants for the three-phase half-bridge control block
`ifndef THB_DEFINES_SVH
`define THB_DEFINES_SVH

// =========================================
// clock and timing
`define THB_CLK_PERIOD_NS 100
`define THB_OSC_NUM 4'h9
`define THB_OSC_DEN 4'ha
`define THB_DEAD_TICKS 2'h3
`define THB_MASK_TIME_NS 4000
`define THB_MASK_CYCLES 8'((`THB_MASK_TIME_NS + `THB_CLK_PERIOD_NS - 1) / `THB_CLK_PERIOD_NS)
`define THB_RESTART_K_MILLI 313
`define THB_RESTART_N_TENTHS 315
`define THB_RECOVERY_CAP_NF 1000
`define THB_RESTART_CYCLES(cnf) \
	((64'd313 * 64'd315 * 64'd100 * 64'(cnf)) / 64'(`THB_CLK_PERIOD_NS))

// =========================================
// register offsets
`define THB_REG_CTRL 8'h00
`define THB_REG_STATUS 8'h04
`define THB_REG_IRQ_STAT 8'h08
`define THB_REG_IRQ_MASK 8'h0c
`define THB_REG_RESTART 8'h10

// =========================================
// field positions and reset values
`define THB_CTRL_ENABLE_BIT 0
`define THB_CTRL_RESET 1'h1
`define THB_EV_THERMAL 0
`define THB_EV_OVERCURRENT 1
`define THB_EV_MOTOR_UV 2
`define THB_EV_REG_UV 3
`define THB_IRQ_MASK_RESET 4'h0

`endif

// >>> rtl/thb_ocp.sv
// overcurrent masking filter and restart hold-off
`include "thb_defines.svh"

module thb_ocp (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// sense and setup
	input wire logic oc_any,
	input wire logic [31:0] restart_cycles,
	// result
	output logic shutdown,
	output logic trip
);

	typedef struct packed {
		thb_pkg::thb_oc_state_t state;
		logic [7:0] mask_cnt;
		logic [31:0] hold_cnt;
		logic trip;
	} thb_ocp_st_t;

	thb_ocp_st_t s_r;
	thb_ocp_st_t s_nxt;

	// short glitches are ignored; only a persistent condition trips
	always_comb begin
		s_nxt = s_r;
		s_nxt.trip = 1'b0;
		case (s_r.state)
			thb_pkg::THB_OC_WATCH: begin
				if (!oc_any) begin
					s_nxt.mask_cnt = 8'h00;
				end else if (s_r.mask_cnt == `THB_MASK_CYCLES - 8'h01) begin
					s_nxt.state = thb_pkg::THB_OC_HOLD;
					s_nxt.trip = 1'b1;
					s_nxt.mask_cnt = 8'h00;
					s_nxt.hold_cnt = 32'h0;
				end else begin
					s_nxt.mask_cnt = s_r.mask_cnt + 8'h01;
				end
			end
			thb_pkg::THB_OC_HOLD: begin
				// zero period treated as one cycle
				if (s_r.hold_cnt + 32'h1 >= restart_cycles) begin
					s_nxt.state = thb_pkg::THB_OC_WATCH;
				end else begin
					s_nxt.hold_cnt = s_r.hold_cnt + 32'h1;
				end
			end
			default: begin
				s_nxt.state = thb_pkg::THB_OC_WATCH;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign shutdown = (s_r.state == thb_pkg::THB_OC_HOLD);
	assign trip = s_r.trip;

endmodule

// >>> rtl/thb_phase.sv
// one half-bridge phase: dead-time delay and drive decode
`include "thb_defines.svh"

module thb_phase (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// control
	input wire logic osc_tick,
	input wire logic clear,
	input wire logic allow,
	input wire thb_pkg::thb_cmd_t cmd,
	// drive
	output thb_pkg::thb_drive_t drive
);

	typedef struct packed {
		logic hi_eff;
		logic [1:0] hi_cnt;
		logic lo_eff;
		logic [1:0] lo_cnt;
		thb_pkg::thb_drive_t drive;
	} thb_phase_st_t;

	thb_phase_st_t s_r;
	thb_phase_st_t s_nxt;

	// falling commands act at once, rising ones only on the third tick
	function automatic logic [2:0] thb_step(input logic cmd_in, input logic eff, input logic [1:0] cnt);
		logic [2:0] res;
		res = {eff, cnt};
		if (!cmd_in) begin
			res = 3'h0;
		end else if (!eff) begin
			if (cnt == `THB_DEAD_TICKS - 2'h1) begin
				res = 3'h4;
			end else begin
				res = {1'b0, cnt + 2'h1};
			end
		end
		return res;
	endfunction

	// next state; clear resets the counters at once, otherwise they move only on oscillator ticks
	always_comb begin
		s_nxt = s_r;
		if (clear) begin
			s_nxt.hi_eff = 1'b0;
			s_nxt.hi_cnt = 2'h0;
			s_nxt.lo_eff = 1'b0;
			s_nxt.lo_cnt = 2'h0;
		end else if (osc_tick) begin
			{s_nxt.hi_eff, s_nxt.hi_cnt} = thb_step(cmd.high, s_r.hi_eff, s_r.hi_cnt);
			{s_nxt.lo_eff, s_nxt.lo_cnt} = thb_step(cmd.low, s_r.lo_eff, s_r.lo_cnt);
		end
		if (osc_tick) begin
			s_nxt.drive.high = allow & s_nxt.hi_eff & ~s_nxt.lo_eff;
			s_nxt.drive.low = allow & s_nxt.lo_eff & ~s_nxt.hi_eff;
		end
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign drive = s_r.drive;

endmodule

// >>> rtl/thb_pkg.sv
// types shared by the half-bridge control block
package thb_pkg;

	// =========================================
	// carriers
	typedef struct packed {
		logic high;
		logic low;
	} thb_cmd_t;

	typedef struct packed {
		logic high;
		logic low;
	} thb_drive_t;

	// =========================================
	// enumerations
	typedef enum logic [0:0] {
		THB_OC_WATCH = 1'b0,
		THB_OC_HOLD = 1'b1
	} thb_oc_state_t;

	typedef enum logic [2:0] {
		THB_SEL_CTRL = 3'b000,
		THB_SEL_STATUS = 3'b001,
		THB_SEL_IRQ_STAT = 3'b010,
		THB_SEL_IRQ_MASK = 3'b011,
		THB_SEL_RESTART = 3'b100,
		THB_SEL_NONE = 3'b111
	} thb_sel_t;

endpackage

// >>> rtl/thb_top.sv
// top of the three-phase half-bridge control block with apb registers
//
// The register addresses and register access over APB were chosen for this implementation.
`include "thb_defines.svh"

// Summary of operation
// - each phase decodes high-only, low-only, otherwise high impedance, independently
// - phase outputs change only on ticks of the internal oscillator
// - a rising command reaches its output three oscillator ticks later
// - over-temperature forces every phase output to high impedance
// - thermal shutdown releases only after the hysteresis release indication
// - motor supply undervoltage disables control and turns all outputs off
// - motor supply lockout ends by itself at the raised release threshold
// - regulator undervoltage disables control and turns all outputs off
// - regulator lockout ends by itself at the raised release threshold
// - overcurrent on any of six transistors shuts all outputs off
// - after overcurrent shutdown outputs stay off for the restart period
// - open-drain overcurrent flag reports an overcurrent shutdown
// - open-drain thermal flag reports active over-temperature protection
// - overcurrent shorter than the four microsecond masking time is ignored
module thb_top #(
	parameter int unsigned RESTART_CYCLES = 32'(`THB_RESTART_CYCLES(`THB_RECOVERY_CAP_NF))
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// interrupt
	output logic irq,
	// phase commands from the controller
	input wire logic phase_one_high_cmd,
	input wire logic phase_one_low_cmd,
	input wire logic phase_two_high_cmd,
	input wire logic phase_two_low_cmd,
	input wire logic phase_three_high_cmd,
	input wire logic phase_three_low_cmd,
	// protection comparators
	input wire logic temp_trip,
	input wire logic temp_release,
	input wire logic motor_supply_low,
	input wire logic motor_supply_ok,
	input wire logic internal_regulator_low,
	input wire logic internal_regulator_ok,
	input wire logic [5:0] current_sense_node_trip,
	// phase drive, index 0 is phase one
	output logic [2:0] phase_drive_high,
	output logic [2:0] phase_drive_low,
	// open-drain flags
	output logic overcurrent_flag_n_o,
	output logic overcurrent_flag_n_oe_n,
	output logic overheat_flag_n_o,
	output logic overheat_flag_n_oe_n
);

	// =========================================
	// state
	typedef struct packed {
		logic [3:0] osc_acc;
		logic osc_tick;
		logic thermal_shutdown;
		logic motor_uv;
		logic reg_uv;
		logic ctrl_enable;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic [31:0] restart;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic irq;
		logic oc_oe_n;
		logic th_oe_n;
		logic flag_lvl;
		logic [2:0] drv_high;
		logic [2:0] drv_low;
	} thb_top_st_t;

	thb_top_st_t s_r;
	thb_top_st_t s_nxt;

	thb_pkg::thb_cmd_t [2:0] cmd;
	thb_pkg::thb_drive_t [2:0] drive;
	logic undervoltage_lockout;
	logic overcurrent_shutdown;
	logic oc_trip;
	logic allow;
	logic [3:0] events;
	logic [31:0] rd_word;
	thb_pkg::thb_sel_t sel;
	logic access;
	logic wr_done;
	logic [4:0] osc_sum;

	// =========================================
	// address decode, shared by read and write paths
	function automatic thb_pkg::thb_sel_t thb_decode(input logic [7:0] addr);
		thb_pkg::thb_sel_t res;
		if (addr == `THB_REG_CTRL) begin
			res = thb_pkg::THB_SEL_CTRL;
		end else if (addr == `THB_REG_STATUS) begin
			res = thb_pkg::THB_SEL_STATUS;
		end else if (addr == `THB_REG_IRQ_STAT) begin
			res = thb_pkg::THB_SEL_IRQ_STAT;
		end else if (addr == `THB_REG_IRQ_MASK) begin
			res = thb_pkg::THB_SEL_IRQ_MASK;
		end else if (addr == `THB_REG_RESTART) begin
			res = thb_pkg::THB_SEL_RESTART;
		end else begin
			res = thb_pkg::THB_SEL_NONE;
		end
		return res;
	endfunction

	// =========================================
	// command gathering
	assign cmd[0] = '{high: phase_one_high_cmd, low: phase_one_low_cmd};
	assign cmd[1] = '{high: phase_two_high_cmd, low: phase_two_low_cmd};
	assign cmd[2] = '{high: phase_three_high_cmd, low: phase_three_low_cmd};

	// either lockout stops the control logic
	assign undervoltage_lockout = s_r.motor_uv | s_r.reg_uv;

	// every protection gates the outputs on its own, none outranks another
	assign allow = s_r.ctrl_enable & ~s_r.thermal_shutdown & ~undervoltage_lockout
		& ~overcurrent_shutdown;

	// =========================================
	// phases
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_phase
			thb_phase u_phase (
				.clk_sys(clk_sys),
				.reset(reset),
				.osc_tick(s_r.osc_tick),
				.clear(undervoltage_lockout),
				.allow(allow),
				.cmd(cmd[gi]),
				.drive(drive[gi])
			);
		end
	endgenerate

	// =========================================
	// overcurrent protection
	thb_ocp u_ocp (
		.clk_sys(clk_sys),
		.reset(reset),
		.oc_any(|current_sense_node_trip),
		.restart_cycles(s_r.restart),
		.shutdown(overcurrent_shutdown),
		.trip(oc_trip)
	);

	// =========================================
	// register read word
	assign sel = thb_decode(paddr);
	assign access = psel & penable;
	assign wr_done = access & pwrite & s_r.pready & (sel != thb_pkg::THB_SEL_NONE);

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_word = 32'h0;
		case (sel)
			thb_pkg::THB_SEL_CTRL: begin
				rd_word[`THB_CTRL_ENABLE_BIT] = s_r.ctrl_enable;
			end
			thb_pkg::THB_SEL_STATUS: begin
				rd_word[0] = s_r.thermal_shutdown;
				rd_word[1] = overcurrent_shutdown;
				rd_word[2] = s_r.motor_uv;
				rd_word[3] = s_r.reg_uv;
				rd_word[6:4] = s_r.drv_high;
				rd_word[10:8] = s_r.drv_low;
			end
			thb_pkg::THB_SEL_IRQ_STAT: begin
				rd_word[3:0] = s_r.irq_stat;
			end
			thb_pkg::THB_SEL_IRQ_MASK: begin
				rd_word[3:0] = s_r.irq_mask;
			end
			thb_pkg::THB_SEL_RESTART: begin
				rd_word = s_r.restart;
			end
			default: begin
				rd_word = 32'h0;
			end
		endcase
	end

	// =========================================
	// next state
	always_comb begin
		s_nxt = s_r;
		events = 4'h0;

		// fractional divider: nine ticks per ten system clocks, about 9 MHz
		// sum kept one bit wider so that it cannot wrap before the compare
		osc_sum = {1'b0, s_r.osc_acc} + {1'b0, `THB_OSC_NUM};
		if (osc_sum >= {1'b0, `THB_OSC_DEN}) begin
			s_nxt.osc_acc = 4'(osc_sum - {1'b0, `THB_OSC_DEN});
			s_nxt.osc_tick = 1'b1;
		end else begin
			s_nxt.osc_acc = s_r.osc_acc + `THB_OSC_NUM;
			s_nxt.osc_tick = 1'b0;
		end

		// thermal latch; trip wins if both comparators claim at once
		if (temp_trip) begin
			s_nxt.thermal_shutdown = 1'b1;
		end else if (temp_release) begin
			s_nxt.thermal_shutdown = 1'b0;
		end

		// motor supply lockout, released with no software action
		if (motor_supply_low) begin
			s_nxt.motor_uv = 1'b1;
		end else if (motor_supply_ok) begin
			s_nxt.motor_uv = 1'b0;
		end

		// regulator lockout, released with no software action
		if (internal_regulator_low) begin
			s_nxt.reg_uv = 1'b1;
		end else if (internal_regulator_ok) begin
			s_nxt.reg_uv = 1'b0;
		end

		// entry edges of each protection state
		events[`THB_EV_THERMAL] = s_nxt.thermal_shutdown & ~s_r.thermal_shutdown;
		events[`THB_EV_OVERCURRENT] = oc_trip;
		events[`THB_EV_MOTOR_UV] = s_nxt.motor_uv & ~s_r.motor_uv;
		events[`THB_EV_REG_UV] = s_nxt.reg_uv & ~s_r.reg_uv;

		// apb answer one cycle into the access phase
		if (access & ~s_r.pready) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = pwrite ? 32'h0 : rd_word;
			s_nxt.pslverr = (sel == thb_pkg::THB_SEL_NONE);
		end else begin
			s_nxt.pready = 1'b0;
			s_nxt.prdata = 32'h0;
			s_nxt.pslverr = 1'b0;
		end

		// writes land on the edge that completes the transfer
		if (wr_done && sel == thb_pkg::THB_SEL_CTRL) begin
			s_nxt.ctrl_enable = pwdata[`THB_CTRL_ENABLE_BIT];
		end
		if (wr_done && sel == thb_pkg::THB_SEL_IRQ_MASK) begin
			s_nxt.irq_mask = pwdata[3:0];
		end
		if (wr_done && sel == thb_pkg::THB_SEL_RESTART) begin
			s_nxt.restart = pwdata;
		end

		// write-one-to-clear, a new event in the same cycle survives
		if (wr_done && sel == thb_pkg::THB_SEL_IRQ_STAT) begin
			s_nxt.irq_stat = (s_r.irq_stat & ~pwdata[3:0]) | events;
		end else begin
			s_nxt.irq_stat = s_r.irq_stat | events;
		end
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

		// flags pull low for as long as the protection holds
		s_nxt.oc_oe_n = ~overcurrent_shutdown;
		s_nxt.th_oe_n = ~s_nxt.thermal_shutdown;
		s_nxt.flag_lvl = 1'b0;

		// local copy of the drive, read back through status
		for (int i = 0; i < 3; i++) begin
			s_nxt.drv_high[i] = drive[i].high;
			s_nxt.drv_low[i] = drive[i].low;
		end
	end

	// =========================================
	// state register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_r <= '0;
			s_r.ctrl_enable <= `THB_CTRL_RESET;
			s_r.irq_mask <= `THB_IRQ_MASK_RESET;
			s_r.restart <= RESTART_CYCLES;
			s_r.oc_oe_n <= 1'b1;
			s_r.th_oe_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// =========================================
	// outputs, all from flops
	assign pready = s_r.pready;
	assign prdata = s_r.prdata;
	assign pslverr = s_r.pslverr;
	assign irq = s_r.irq;
	assign overcurrent_flag_n_o = s_r.flag_lvl;
	assign overcurrent_flag_n_oe_n = s_r.oc_oe_n;
	assign overheat_flag_n_o = s_r.flag_lvl;
	assign overheat_flag_n_oe_n = s_r.th_oe_n;

	// phase drive straight from the phase flops
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			phase_drive_high[i] = drive[i].high;
			phase_drive_low[i] = drive[i].low;
		end
	end

endmodule

// >>> sim/thb_chk.sv
// assertion checker for the half-bridge control block
module thb_chk #(
	parameter int unsigned RESTART_CYCLES = 50
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// watched inputs
	input wire logic phase_one_high_cmd,
	input wire logic phase_one_low_cmd,
	input wire logic temp_trip,
	input wire logic temp_release,
	input wire logic motor_supply_low,
	input wire logic internal_regulator_low,
	input wire logic [5:0] current_sense_node_trip,
	// watched outputs
	input wire logic [2:0] phase_drive_high,
	input wire logic [2:0] phase_drive_low,
	input wire logic overcurrent_flag_n_o,
	input wire logic overcurrent_flag_n_oe_n,
	input wire logic overheat_flag_n_o,
	input wire logic overheat_flag_n_oe_n
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic [5:0] oc_run_r;
	logic [31:0] low_cnt_r;
	logic all_off;
	assign all_off = (phase_drive_high == 3'h0) && (phase_drive_low == 3'h0);
	// run length of a fault and length of a flag hold; saturating so long faults never wrap
	always_ff @(posedge clk_sys) begin
		if (reset || current_sense_node_trip == 6'h00) oc_run_r <= 6'h00;
		else if (oc_run_r != 6'h3f) oc_run_r <= oc_run_r + 6'h01;
		if (reset || overcurrent_flag_n_oe_n) low_cnt_r <= 32'h0;
		else low_cnt_r <= low_cnt_r + 32'h1;
	end
	property p_no_shoot; !(|(phase_drive_high & phase_drive_low)); endproperty
	a_no_shoot: assert property (p_no_shoot) else $error("both sides driven");
	property p_dead; $rose(phase_one_high_cmd) && !phase_one_low_cmd && !phase_drive_high[0]
		|=> !phase_drive_high[0] [*2]; endproperty
	a_dead: assert property (p_dead) else $error("rising command too early");
	property p_hot_off; temp_trip |-> ##[1:4] all_off; endproperty
	a_hot_off: assert property (p_hot_off) else $error("outputs on while hot");
	property p_hot_hold; !overheat_flag_n_oe_n && !temp_release && !$past(temp_release)
		&& !$past(temp_release, 2) |=> !overheat_flag_n_oe_n; endproperty
	a_hot_hold: assert property (p_hot_hold) else $error("thermal released early");
	property p_muv_off; motor_supply_low |-> ##[1:4] all_off; endproperty
	a_muv_off: assert property (p_muv_off) else $error("outputs on in motor lockout");
	property p_ruv_off; $rose(internal_regulator_low) |-> ##[1:4] all_off; endproperty
	a_ruv_off: assert property (p_ruv_off) else $error("outputs on in regulator lockout");
	property p_oc_long; oc_run_r == 6'd44 |-> !overcurrent_flag_n_oe_n; endproperty
	a_oc_long: assert property (p_oc_long) else $error("long overcurrent ignored");
	property p_restart; $rose(overcurrent_flag_n_oe_n)
		|-> low_cnt_r + 32'd2 >= RESTART_CYCLES && low_cnt_r <= RESTART_CYCLES + 32'd2; endproperty
	a_restart: assert property (p_restart) else $error("restart hold length wrong");
	property p_hot_flag; temp_trip |-> ##[1:3] !overheat_flag_n_oe_n; endproperty
	a_hot_flag: assert property (p_hot_flag) else $error("thermal flag missing");
	property p_oc_short; overcurrent_flag_n_oe_n && oc_run_r < 6'd30 |=> overcurrent_flag_n_oe_n; endproperty
	a_oc_short: assert property (p_oc_short) else $error("short overcurrent tripped");
	property p_flag_off; !overcurrent_flag_n_oe_n [*3] |-> all_off && !overcurrent_flag_n_o
		&& !overheat_flag_n_o; endproperty
	a_flag_off: assert property (p_flag_off) else $error("flag active with outputs on");
endmodule

bind thb_top thb_chk #(.RESTART_CYCLES(RESTART_CYCLES)) chk_u (.clk_sys, .reset, .phase_one_high_cmd,
	.phase_one_low_cmd, .temp_trip, .temp_release, .motor_supply_low, .internal_regulator_low,
	.current_sense_node_trip, .phase_drive_high, .phase_drive_low, .overcurrent_flag_n_o,
	.overcurrent_flag_n_oe_n, .overheat_flag_n_o, .overheat_flag_n_oe_n);

// >>> sim/thb_ctrl_model.sv
// controller model that drives the phase commands
module thb_ctrl_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// wishes and fault sense
	input wire thb_pkg::thb_cmd_t [2:0] req,
	input wire logic obey,
	input wire logic fault,
	// phase commands
	output thb_pkg::thb_cmd_t [2:0] cmd
);
	// obedient mode halts on a flag and never asks for both sides
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 3; i++) begin
			if (reset || (obey && (fault || (req[i].high && req[i].low)))) begin
				cmd[i] <= '0;
			end else begin
				cmd[i] <= req[i];
			end
		end
	end
endmodule

// >>> sim/three_phase_half_bridge_ctrl_tb_top.sv
// self-checking bench for the half-bridge control block
`include "thb_defines.svh"
module three_phase_half_bridge_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned RST = 50; // short restart hold keeps the run brief
	logic clk_sys, reset, psel, penable, pwrite, temp_trip, temp_release, pready, pslverr, irq, e, obey;
	logic oc_pin, ot_pin, overcurrent_flag_n_o, overcurrent_flag_n_oe_n, overheat_flag_n_o, overheat_flag_n_oe_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, lfsr;
	logic [1:0] uv_low, uv_ok;
	logic [5:0] current_sense_node_trip;
	logic [2:0] phase_drive_high, phase_drive_low;
	thb_pkg::thb_cmd_t [2:0] req, cmd;
	int fails, num_checks, n, j;
	int cyc = 0;
	// open-drain flag pins with pull-ups
	assign oc_pin = overcurrent_flag_n_oe_n ? 1'b1 : overcurrent_flag_n_o;
	assign ot_pin = overheat_flag_n_oe_n ? 1'b1 : overheat_flag_n_o;
	thb_ctrl_model ctl_u (.clk_sys, .reset, .req, .obey, .fault(!(oc_pin && ot_pin)), .cmd);
	thb_top #(.RESTART_CYCLES(RST)) dut_u (.clk_sys, .reset, .paddr, .psel, .penable, .pwrite, .pwdata,
		.pready, .prdata, .pslverr, .irq, .phase_one_high_cmd(cmd[0].high), .phase_one_low_cmd(cmd[0].low),
		.phase_two_high_cmd(cmd[1].high), .phase_two_low_cmd(cmd[1].low), .phase_three_high_cmd(cmd[2].high),
		.phase_three_low_cmd(cmd[2].low), .temp_trip, .temp_release, .motor_supply_low(uv_low[0]),
		.motor_supply_ok(uv_ok[0]), .internal_regulator_low(uv_low[1]), .internal_regulator_ok(uv_ok[1]),
		.current_sense_node_trip, .phase_drive_high, .phase_drive_low, .overcurrent_flag_n_o,
		.overcurrent_flag_n_oe_n, .overheat_flag_n_o, .overheat_flag_n_oe_n);
	// clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// hang guard
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			stop_test();
		end
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction
	// expected {high, low} drives from one command word
	function automatic logic [5:0] exp_drv(input logic [5:0] r);
		logic [2:0] h, l;
		for (int i = 0; i < 3; i++) begin
			h[i] = r[2*i+1] & ~r[2*i];
			l[i] = r[2*i] & ~r[2*i+1];
		end
		return {h, l};
	endfunction
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			fails++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	// one apb transfer; pready, read data and error all taken at the completing rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clk_sys);
			t++;
		end while (pready !== 1'b1 && t < 20);
		chk(pready === 1'b1, "apb no answer");
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		{fails, num_checks} = 0;
		{reset, psel, penable, pwrite, paddr, pwdata, temp_trip, temp_release} = {1'b1, 45'h0};
		{uv_low, uv_ok, current_sense_node_trip, req, obey} = 17'h0;
		lfsr = 32'hb7019605;
		wt(10);
		reset <= 1'b0;
		apb(1'b0, `THB_REG_CTRL, 32'h0);
		chk(q === 32'(`THB_CTRL_RESET), "ctrl reset");
		apb(1'b0, `THB_REG_RESTART, 32'h0);
		chk(q === 32'(RST), "restart reset");
		apb(1'b0, 8'h40, 32'h0);
		chk(e === 1'b1 && q === 32'h0, "unmapped");
		apb(1'b1, `THB_REG_IRQ_MASK, 32'h1);
		// decode: four corners then random words
		for (j = 0; j < 16; j++) begin
			lfsr = lfsr_next(lfsr);
			@(posedge clk_sys);
			req <= (j < 4) ? {3{j[1:0]}} : lfsr[5:0];
			wt(8);
			@(negedge clk_sys);
			chk({phase_drive_high, phase_drive_low} === exp_drv(req), "decode");
		end
		// rising command waits, falling one does not; start from all off so the rise is real
		@(posedge clk_sys);
		req <= 6'h00;
		wt(8);
		req <= 6'h02;
		while (cmd[0].high !== 1'b1) @(negedge clk_sys);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (phase_drive_high[0] !== 1'b1 && n < 12);
		chk(n >= 3 && n <= 6, "dead time");
		@(posedge clk_sys);
		req <= 6'h28;
		obey <= 1'b1;
		while (cmd[0].high !== 1'b0) @(negedge clk_sys);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (phase_drive_high[0] !== 1'b0 && n < 12);
		chk(n <= 3, "fall slow");
		wt(8);
		// thermal trip, hold without release, interrupt, then release
		temp_trip <= 1'b1;
		wt(2);
		temp_trip <= 1'b0;
		wt(4);
		@(negedge clk_sys);
		chk({phase_drive_high, phase_drive_low} === 6'h00, "hot outputs");
		chk(ot_pin === 1'b0 && irq === 1'b1, "hot flag");
		wt(20);
		@(negedge clk_sys);
		chk({phase_drive_high, phase_drive_low, ot_pin} === 7'h00, "hot hold");
		apb(1'b0, `THB_REG_IRQ_STAT, 32'h0);
		chk(q[3:0] === 4'h1, "stat");
		apb(1'b1, `THB_REG_IRQ_STAT, 32'h1);
		@(negedge clk_sys);
		chk(irq === 1'b0, "irq clear");
		@(posedge clk_sys);
		temp_release <= 1'b1;
		wt(2);
		temp_release <= 1'b0;
		wt(8);
		@(negedge clk_sys);
		chk({phase_drive_high, phase_drive_low} === exp_drv(req) && ot_pin === 1'b1, "cool");
		// software switches the outputs off, status reads back idle, then on again
		apb(1'b1, `THB_REG_CTRL, 32'h0);
		wt(4);
		@(negedge clk_sys);
		chk({phase_drive_high, phase_drive_low} === 6'h00, "ctrl off");
		apb(1'b0, `THB_REG_STATUS, 32'h0);
		chk(q === 32'h0, "status idle");
		apb(1'b1, `THB_REG_CTRL, 32'h1);
		// both lockouts, masked events, automatic recovery
		for (j = 0; j < 2; j++) begin
			@(posedge clk_sys);
			uv_low[j] <= 1'b1;
			wt(2);
			uv_low[j] <= 1'b0;
			wt(4);
			@(negedge clk_sys);
			chk({phase_drive_high, phase_drive_low, irq} === 7'h00, "lockout");
			@(posedge clk_sys);
			uv_ok[j] <= 1'b1;
			wt(2);
			uv_ok[j] <= 1'b0;
			wt(8);
			@(negedge clk_sys);
			chk({phase_drive_high, phase_drive_low} === exp_drv(req), "recover");
		end
		apb(1'b0, `THB_REG_IRQ_STAT, 32'h0);
		chk(q[3:0] === 4'hc, "masked events");
		apb(1'b1, `THB_REG_IRQ_STAT, 32'hc);
		// short burst ignored, long fault on each sensor trips and recovers
		lfsr = lfsr_next(lfsr);
		@(posedge clk_sys);
		current_sense_node_trip <= 6'h01 << (lfsr % 32'd6);
		wt(36);
		current_sense_node_trip <= 6'h00;
		wt(4);
		@(negedge clk_sys);
		chk(oc_pin === 1'b1 && {phase_drive_high, phase_drive_low} === exp_drv(req), "burst");
		for (j = 0; j < 6; j++) begin
			@(posedge clk_sys);
			current_sense_node_trip <= 6'h01 << j;
			wt(45);
			@(negedge clk_sys);
			chk({oc_pin, phase_drive_high, phase_drive_low} === 7'h00, "trip");
			@(posedge clk_sys);
			current_sense_node_trip <= 6'h00;
			n = 0;
			do begin
				@(negedge clk_sys);
				n++;
			end while (oc_pin !== 1'b1 && n < 200);
			chk(n + 8 >= RST && n <= RST, "restart hold");
			wt(8);
			@(negedge clk_sys);
			chk({phase_drive_high, phase_drive_low} === exp_drv(req), "resume");
		end
		stop_test();
	end
endmodule
